// ### design/ctx_leaf_pkg.sv
package ctx_leaf_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_RAX      = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  // ctrl fields
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE64 = 1;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_ZF   = 1;
  localparam int ST_CF   = 2;
  localparam int ST_PF   = 3;
  localparam int ST_AF   = 4;
  localparam int ST_OF   = 5;
  localparam int ST_SF   = 6;
  localparam int ST_GP   = 7;
  localparam int ST_PFLT = 8;
  localparam int ST_ENC  = 9;
  localparam int ST_UD   = 10;
  // irq event bits
  localparam int EV_DONE = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_CONFLICT = 2;
  localparam int EV_W = 3;
  // feature control word bits
  localparam int FC_LOCK = 0;
  localparam int FC_ENABLE = 18;
  // alignment masks
  localparam logic [63:0] PAGE_MASK = 64'h0000_0000_0000_0fff;
  localparam logic [63:0] WORD_MASK = 64'h0000_0000_0000_0007;
  localparam logic [3:0] CONTROL_PAGE_TYPE = 4'h0;
  localparam logic [63:0] PAGE_CONFLICT_CODE = 64'h0000_0000_0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### design/set_context_leaf.sv
`timescale 1ns/1ps
// Operation
// - control page address not 4KByte aligned gives GP fault, code zero
// - control page address outside protected page cache gives enclave PF
// - context source address not 8Byte aligned gives GP fault, code zero
// - after those checks, read 64-bit context into staged_context first
// - page busy: ZF=1, CF=0, RAX=conflict code, skip to flag clearing
// - page cache map entry invalid gives enclave page fault
// - map entry type not control page type gives enclave page fault
// - all pass: write staged value to context_field, RAX=0, ZF=0
// - success and conflict both clear CF, PF, AF, OF, SF
// - 32-bit mode: beyond data segment limit or unusable gives GP
// - 64-bit mode: non-canonical operand address gives GP fault
// - paging fault on either operand gives ordinary page fault
// - addresses always built from data segment, overrides ignored
// - create/load sets context_field to page address; this leaf replaces
// - available only in protected mode, not system management or v8086
// - every leaf needs paging_enable_bit set
// - needs feature_control_word bit 18 and lock bit 0 set
module set_context_leaf (
  input  wire logic        mclk,          // 200 MHz core clock
  input  wire logic        rst,           // sync reset, active high
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read valid
  input  wire logic        s_axi_rready,  // read ready
  input  wire logic [63:0] page_addr,     // DS-based linear addr of page
  input  wire logic [63:0] src_addr,      // DS-based linear addr of value
  input  wire logic [31:0] ds_limit,      // data segment limit
  input  wire logic        ds_usable,     // data segment usable
  input  wire logic        protected_mode, // protected mode active
  input  wire logic        system_management_state, // in smm-like state
  input  wire logic        virtual_8086_state, // in v8086 state
  input  wire logic        paging_enable_bit, // paging on
  input  wire logic [63:0] feature_control_word, // feature control
  input  wire logic        page_in_cache, // page resolves in cache
  input  wire logic        map_valid,     // page_cache_map valid bit
  input  wire logic [3:0]  map_type,      // page_cache_map page type
  input  wire logic        page_busy,     // other op modifying page
  input  wire logic        paging_fault,  // translation faulted
  input  wire logic [63:0] mem_rdata,     // context value at src_addr
  output logic             page_lock,     // holds page during S_ATOMIC check; low when ctx_we pulses
  output logic             ctx_we,        // context_field write strobe
  output logic [63:0]      ctx_wdata,     // context_field write data
  output logic             irq            // level interrupt
);

  typedef enum logic [2:0] {
    S_IDLE, S_CHECK, S_READ, S_ATOMIC, S_DONE
  } state_t;

  state_t      state_reg;
  logic [31:0] ctrl_reg;
  logic [10:0] status_reg;
  logic [63:0] rax_reg;
  logic [63:0] staged_context_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_mask_reg;
  logic [2:0]  ev_set;
  logic        mode64;
  logic        enabled;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        start;
  logic        seg_bad;

  function automatic logic canonical(input logic [63:0] a);
    canonical = (a[63:47] == {17{a[47]}});
  endfunction

  function automatic logic seg_ok(input logic [63:0] a,
                                  input logic [31:0] lim);
    seg_ok = (a[63:32] == 32'h0000_0000) && (a[31:0] <= lim);
  endfunction

  // operand addresses are always data-segment based; override never seen
  assign mode64 = ctrl_reg[ctx_leaf_pkg::CTRL_MODE64];
  assign enabled = protected_mode && !system_management_state
                   && !virtual_8086_state
                   && paging_enable_bit
                   && feature_control_word[ctx_leaf_pkg::FC_ENABLE]
                   && feature_control_word[ctx_leaf_pkg::FC_LOCK];
  assign seg_bad = mode64
    ? (!canonical(page_addr) || !canonical(src_addr))
    : (!ds_usable || !seg_ok(page_addr, ds_limit)
       || !seg_ok(src_addr + 64'h7, ds_limit));

  // ---------------- bus slave ----------------
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready  = !w_hold_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign start = wr_fire && (aw_addr_reg == ctx_leaf_pkg::OFF_CTRL)
                 && w_strb_reg[0] && w_data_reg[ctx_leaf_pkg::CTRL_START]
                 && (state_reg == S_IDLE);

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ctx_leaf_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg > ctx_leaf_pkg::OFF_IRQ_MASK
                        || aw_addr_reg[1:0] != 2'b00)
                       ? ctx_leaf_pkg::RESP_SLVERR : ctx_leaf_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= 32'h0000_0000;
      irq_mask_reg <= 3'h0;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == ctx_leaf_pkg::OFF_CTRL) begin
        ctrl_reg <= {30'h0, w_data_reg[1], 1'b0};
      end
      if (aw_addr_reg == ctx_leaf_pkg::OFF_IRQ_MASK) begin
        irq_mask_reg <= w_data_reg[2:0];
      end
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_stat_reg <= 3'h0;
    end else if (wr_fire && w_strb_reg[0]
                 && aw_addr_reg == ctx_leaf_pkg::OFF_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~w_data_reg[2:0]) | ev_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | ev_set;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ctx_leaf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ctx_leaf_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ctx_leaf_pkg::OFF_CTRL:     s_axi_rdata <= ctrl_reg;
        ctx_leaf_pkg::OFF_STATUS:   s_axi_rdata <= {21'h0, status_reg};
        ctx_leaf_pkg::OFF_RAX:      s_axi_rdata <= rax_reg[31:0];
        ctx_leaf_pkg::OFF_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_reg};
        ctx_leaf_pkg::OFF_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ctx_leaf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- leaf sequencer ----------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      status_reg <= 11'h000;
      rax_reg <= 64'h0;
      staged_context_reg <= 64'h0;
      ev_set <= 3'h0;
      page_lock <= 1'b0;
      ctx_we <= 1'b0;
      ctx_wdata <= 64'h0;
    end else begin
      ev_set <= 3'h0;
      ctx_we <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            status_reg <= 11'h001;
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          state_reg <= S_DONE;
          if (!enabled) begin
            status_reg[ctx_leaf_pkg::ST_UD] <= 1'b1;
          end else if (seg_bad) begin
            status_reg[ctx_leaf_pkg::ST_GP] <= 1'b1;
          end else if ((page_addr & ctx_leaf_pkg::PAGE_MASK) != 64'h0) begin
            status_reg[ctx_leaf_pkg::ST_GP] <= 1'b1;
          end else if (!page_in_cache) begin
            status_reg[ctx_leaf_pkg::ST_PFLT] <= 1'b1;
            status_reg[ctx_leaf_pkg::ST_ENC] <= 1'b1;
          end else if ((src_addr & ctx_leaf_pkg::WORD_MASK) != 64'h0) begin
            status_reg[ctx_leaf_pkg::ST_GP] <= 1'b1;
          end else if (paging_fault) begin
            status_reg[ctx_leaf_pkg::ST_PFLT] <= 1'b1;
          end else begin
            state_reg <= S_READ;
          end
        end
        S_READ: begin
          staged_context_reg <= mem_rdata;
          page_lock <= 1'b1;
          state_reg <= S_ATOMIC;
        end
        S_ATOMIC: begin
          state_reg <= S_DONE;
          page_lock <= 1'b0;
          if (page_busy) begin
            status_reg[ctx_leaf_pkg::ST_ZF] <= 1'b1;
            rax_reg <= ctx_leaf_pkg::PAGE_CONFLICT_CODE;
          end else if (!map_valid) begin
            status_reg[ctx_leaf_pkg::ST_PFLT] <= 1'b1;
            status_reg[ctx_leaf_pkg::ST_ENC] <= 1'b1;
          end else if (map_type != ctx_leaf_pkg::CONTROL_PAGE_TYPE) begin
            status_reg[ctx_leaf_pkg::ST_PFLT] <= 1'b1;
            status_reg[ctx_leaf_pkg::ST_ENC] <= 1'b1;
          end else begin
            ctx_we <= 1'b1;
            ctx_wdata <= staged_context_reg;
            rax_reg <= 64'h0;
            status_reg[ctx_leaf_pkg::ST_ZF] <= 1'b0;
          end
        end
        S_DONE: begin
          // flags other than zf already clear from start
          status_reg[ctx_leaf_pkg::ST_BUSY] <= 1'b0;
          status_reg[6:2] <= 5'h00;
          ev_set[ctx_leaf_pkg::EV_DONE] <= 1'b1;
          ev_set[ctx_leaf_pkg::EV_FAULT] <=
            |status_reg[ctx_leaf_pkg::ST_UD:ctx_leaf_pkg::ST_GP];
          ev_set[ctx_leaf_pkg::EV_CONFLICT] <= status_reg[ctx_leaf_pkg::ST_ZF];
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ---------------- assertions ----------------
  sequence s_conflict;
    state_reg == S_ATOMIC && page_busy;
  endsequence

  property p_align_gp;
    @(posedge mclk) disable iff (rst)
    state_reg == S_CHECK && enabled && !seg_bad && page_addr[11:0] != 12'h0
    |=> status_reg[ctx_leaf_pkg::ST_GP] && state_reg == S_DONE;
  endproperty
  a_align_gp: assert property (p_align_gp)
    else $error("misaligned page did not fault");

  property p_src_gp;
    @(posedge mclk) disable iff (rst)
    state_reg == S_CHECK && enabled && !seg_bad && page_addr[11:0] == 12'h0
    && page_in_cache && src_addr[2:0] != 3'h0
    |=> status_reg[ctx_leaf_pkg::ST_GP];
  endproperty
  a_src_gp: assert property (p_src_gp)
    else $error("misaligned source did not fault");

  property p_conflict;
    @(posedge mclk) disable iff (rst)
    s_conflict |=> status_reg[ctx_leaf_pkg::ST_ZF] && !ctx_we
    && rax_reg == ctx_leaf_pkg::PAGE_CONFLICT_CODE;
  endproperty
  a_conflict: assert property (p_conflict)
    else $error("conflict not reported");

  property p_write;
    @(posedge mclk) disable iff (rst)
    ctx_we |-> ctx_wdata == $past(staged_context_reg) && rax_reg == 64'h0
    && !status_reg[ctx_leaf_pkg::ST_ZF];
  endproperty
  a_write: assert property (p_write)
    else $error("context write wrong");

  property p_flags_clear;
    @(posedge mclk) disable iff (rst)
    state_reg == S_DONE |=> status_reg[6:2] == 5'h00 && state_reg == S_IDLE;
  endproperty
  a_flags_clear: assert property (p_flags_clear)
    else $error("flags not cleared");

  property p_gate;
    @(posedge mclk) disable iff (rst)
    state_reg == S_CHECK && !enabled
    |=> status_reg[ctx_leaf_pkg::ST_UD] ##1 state_reg == S_IDLE;
  endproperty
  a_gate: assert property (p_gate)
    else $error("disabled leaf ran");

  property p_invalid;
    @(posedge mclk) disable iff (rst)
    state_reg == S_ATOMIC && !page_busy && !map_valid
    |=> status_reg[ctx_leaf_pkg::ST_ENC] && !ctx_we;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("invalid map entry accepted");

  property p_atomic;
    @(posedge mclk) disable iff (rst)
    $rose(page_lock) |=> !page_lock && state_reg == S_DONE;
  endproperty
  a_atomic: assert property (p_atomic)
    else $error("lock window wrong");

endmodule // set_context_leaf

// ### testbench/set_context_leaf_tb_top.sv
`timescale 1ns/1ps
module set_context_leaf_tb_top;
  logic        mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, ds_usable;
  logic        protected_mode, system_management_state, virtual_8086_state;
  logic        paging_enable_bit, page_in_cache, map_valid, page_busy;
  logic        paging_fault, page_lock, ctx_we, irq, m64;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [3:0]  s_axi_wstrb, map_type;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ds_limit, rd;
  logic [63:0] page_addr, src_addr, feature_control_word, mem_rdata;
  logic [63:0] ctx_wdata, last_wd, exp_st;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          n_we = 0;
  int          we_before;
  int          n_lock = 0;
  int          lock_before;
  localparam logic [63:0] GP = 64'h1 << ctx_leaf_pkg::ST_GP;
  localparam logic [63:0] PFO = 64'h1 << ctx_leaf_pkg::ST_PFLT;
  localparam logic [63:0] EPF = PFO | (64'h1 << ctx_leaf_pkg::ST_ENC);
  localparam logic [63:0] UD = 64'h1 << ctx_leaf_pkg::ST_UD;
  localparam logic [63:0] ZF = 64'h1 << ctx_leaf_pkg::ST_ZF;
  // busy plus the fault bits; flags are left open on a fault
  localparam logic [63:0] FMASK = 64'h0000_0000_0000_0781;

  set_context_leaf dut_u (
    .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .page_addr, .src_addr, .ds_limit, .ds_usable,
    .protected_mode, .system_management_state, .virtual_8086_state,
    .paging_enable_bit, .feature_control_word, .page_in_cache, .map_valid,
    .map_type, .page_busy, .paging_fault, .mem_rdata, .page_lock, .ctx_we,
    .ctx_wdata, .irq
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (ctx_we === 1'b1) begin
      n_we <= n_we + 1;
      last_wd <= ctx_wdata;
    end
    // lock cycles seen; one is expected per leaf reaching the atomic step
    if (page_lock === 1'b1) begin
      n_lock <= n_lock + 1;
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle limit here: only the watchdog ends a stuck wait
    while (!done) begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    bit done;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // start the leaf and poll busy, leaving the final status in rd
  task automatic run_leaf();
    axi_wr(ctx_leaf_pkg::OFF_CTRL, {30'h0, m64, 1'b1});
    rd = 32'h1;
    for (int k = 0; k < 40 && rd[ctx_leaf_pkg::ST_BUSY] !== 1'b0; k++)
      axi_rd(ctx_leaf_pkg::OFF_STATUS);
  endtask

  // a legal leaf request: every check passes
  task automatic defaults();
    page_addr <= 64'h0000_0000_1234_5000;
    src_addr <= 64'h0000_0000_0000_2008;
    ds_limit <= 32'hffff_ffff;
    ds_usable <= 1'b1;
    protected_mode <= 1'b1;
    system_management_state <= 1'b0;
    virtual_8086_state <= 1'b0;
    paging_enable_bit <= 1'b1;
    feature_control_word <= 64'h0000_0000_0004_0001;
    page_in_cache <= 1'b1;
    map_valid <= 1'b1;
    map_type <= ctx_leaf_pkg::CONTROL_PAGE_TYPE;
    page_busy <= 1'b0;
    paging_fault <= 1'b0;
    // blocking: run_leaf reads the mode in this same time step
    m64 = 1'b1;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    mem_rdata = 64'h0;
    defaults();
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    axi_rd(ctx_leaf_pkg::OFF_STATUS);
    check("status after reset", 64'(rd), 64'h0);
    for (int c = 0; c < 18; c++) begin
      @(posedge mclk);
      defaults();
      mem_rdata <= 64'h8765_4321_0fed_c000 + 64'(c);
      exp_st = 64'h0;
      case (c)
        0: begin page_busy <= 1'b1; exp_st = ZF; end
        2: m64 = 1'b0;
        3: begin page_addr <= 64'h0000_0000_1234_5800; exp_st = GP; end
        4: begin page_in_cache <= 1'b0; exp_st = EPF; end
        5: begin src_addr <= 64'h0000_0000_0000_2004; exp_st = GP; end
        6: begin map_valid <= 1'b0; exp_st = EPF; end
        7: begin map_type <= 4'h1; exp_st = EPF; end
        8: begin paging_fault <= 1'b1; exp_st = PFO; end
        9: begin page_addr <= 64'h8000_0000_1234_5000; exp_st = GP; end
        10: begin m64 = 1'b0; ds_limit <= 32'h2000; exp_st = GP; end
        11: begin m64 = 1'b0; ds_usable <= 1'b0; exp_st = GP; end
        12: begin protected_mode <= 1'b0; exp_st = UD; end
        13: begin system_management_state <= 1'b1; exp_st = UD; end
        14: begin virtual_8086_state <= 1'b1; exp_st = UD; end
        15: begin paging_enable_bit <= 1'b0; exp_st = UD; end
        16: begin feature_control_word <= 64'h4_0000; exp_st = UD; end
        17: begin feature_control_word <= 64'h1; exp_st = UD; end
        default: ;
      endcase
      // case 1 is the 64-bit success after a conflict
      if (c == 1 || c == 2) mem_rdata <= 64'h8765_4321_0fed_c000 + 64'(c);
      we_before = n_we;
      lock_before = n_lock;
      run_leaf();
      check("status", rd & (c < 3 ? 64'h7ff : FMASK), exp_st);
      check("ctx writes", 64'(n_we - we_before), 64'(c == 1 || c == 2));
      // map entry faults are found inside the locked step, so they lock too
      exp_st = 64'(c < 3 || c == 6 || c == 7);
      check("lock cycles", 64'(n_lock - lock_before), exp_st);
      if (c < 3) begin
        axi_rd(ctx_leaf_pkg::OFF_RAX);
        exp_st = (c == 0) ? ctx_leaf_pkg::PAGE_CONFLICT_CODE : 64'h0;
        check("rax", 64'(rd), exp_st);
      end
      if (c == 1 || c == 2)
        check("ctx data", last_wd, 64'h8765_4321_0fed_c000 + 64'(c));
      $display("leaf test %0d finished", c);
    end
    axi_rd(ctx_leaf_pkg::OFF_IRQ_STAT);
    check("irq status", 64'(rd), 64'h7);
    check("irq masked", 64'(irq), 64'h0);
    axi_wr(ctx_leaf_pkg::OFF_IRQ_MASK, 32'h4);
    check("irq unmasked", 64'(irq), 64'h1);
    axi_rd(ctx_leaf_pkg::OFF_IRQ_MASK);
    check("irq mask", 64'(rd), 64'h4);
    axi_wr(ctx_leaf_pkg::OFF_IRQ_STAT, 32'h4);
    check("irq cleared", 64'(irq), 64'h0);
    axi_rd(ctx_leaf_pkg::OFF_IRQ_STAT);
    check("irq status after clear", 64'(rd), 64'h3);
    $display("interrupt test finished");
    axi_wr(8'h20, 32'h5);
    check("unmapped write resp", 64'(resp), 64'(ctx_leaf_pkg::RESP_SLVERR));
    axi_rd(8'h14);
    check("unmapped read resp", 64'(resp), 64'(ctx_leaf_pkg::RESP_SLVERR));
    check("unmapped read data", 64'(rd), 64'h0);
    $display("unmapped access test finished");
    finish_test();
  end
endmodule // set_context_leaf_tb_top
